//--- rtl/sgpb_pkg.sv
package sgpb_pkg;

    // Bus geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_LSB = 2;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_PORTB_DATA = 6'h01;
    localparam logic [5:0] IDX_PORTC_DATA = 6'h02;
    localparam logic [5:0] IDX_PORTD_DATA = 6'h03;
    localparam logic [5:0] IDX_PORTB_DIRECTION = 6'h05;
    localparam logic [5:0] IDX_PORTC_DIRECTION_CLKOUT = 6'h06;
    localparam logic [5:0] IDX_PORTD_DIRECTION = 6'h07;

    // Field positions.
    localparam int CLKOUT_EN_BIT = 7;
    localparam int CLKOUT_PIN = 2;
    localparam int PORTC_WIDTH = 6;
    localparam int TIMER_A_PIN = 6;
    localparam int TIMER_B_PIN = 4;
    localparam int PORTD_CONV_PINS = 7;

    // Converter channel numbers of the first pin of each shared port.
    localparam logic [4:0] CONV_PORTB_FIRST = 5'h00;
    localparam logic [4:0] CONV_PORTD_FIRST = 5'h08;

    // Prescaler select code that picks the external timer clock.
    localparam logic [2:0] PRESCALE_EXTERNAL = 3'h7;

    // Reset values.
    localparam logic [7:0] DIRECTION_RESET = 8'h00;
    localparam logic [7:0] OE_N_RESET = 8'hff;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One bundle of pin levels for the three ports.
    typedef struct packed {
        logic [7:0] b;
        logic [5:0] c;
        logic [7:0] d;
    } sgpb_pins_t;

endpackage

//--- rtl/sgpb_top.sv
// Notes on behaviour
// - Port B latches survive reset unchanged.
// - Port B direction 1 drives; reset clears.
// - Port B read: latch if output, else pin.
// - Data latches writable in any direction, except C2 while clock-out is on.
// - Converter-selected input pin reads as zero.
// - Converter use overrides port B drive.
// - Clock-output enable drives clock on C2.
// - Clock-out ignores C2 direction; reset clears.
// - Port C latches kept; read latch or pin; C2 reads zero while clock-out is on.
// - Port C directions reset to input.
// - Port D read: latch if output, else pin; timer-selected input reads zero.
// - Port D converter-selected input reads zero.
// - External timer clocks taken from D6, D4.
// - Timer pins ignore direction for drive.
// - Port D directions reset to input.
//
// Our own choice: the AXI4-Lite interface to the registers.
module sgpb_top (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // AXI4-Lite write address and data.
    input wire logic [sgpb_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [sgpb_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response.
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read.
    input wire logic [sgpb_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [sgpb_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Selects from the converter and the timers.
    input wire logic [4:0] converterChannelSelect,
    input wire logic [2:0] timerAPrescalerSelect,
    input wire logic [2:0] timerBPrescalerSelect,
    // Pins.
    input wire sgpb_pkg::sgpb_pins_t pinsIn,
    output sgpb_pkg::sgpb_pins_t pinsOut,
    output sgpb_pkg::sgpb_pins_t pinsOeN,
    // External timer clocks.
    output logic timerAExternalClock,
    output logic timerBExternalClock
);

    // Registers and synchronisers.
    logic [7:0] portbData;
    logic [5:0] portcData;
    logic [7:0] portdData;
    logic [7:0] portbDirection;
    logic [5:0] portcDirection;
    logic clockOutputEnable;
    logic [7:0] portdDirection;
    sgpb_pkg::sgpb_pins_t pinMeta;
    sgpb_pkg::sgpb_pins_t pinSync;

    // Bus state.
    logic awHeld;
    logic wHeld;
    logic [sgpb_pkg::ADDR_W-1:0] wrAddr;
    logic [7:0] wrData;
    logic wrLane;
    logic next_awHeld;
    logic next_wHeld;
    logic wrDo;

    // Converter and timer pin ownership.
    logic [7:0] convB;
    logic [7:0] convD;
    logic timerASel;
    logic timerBSel;
    logic [7:0] timerD;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_conv
            assign convB[gi] = converterChannelSelect ==
                sgpb_pkg::CONV_PORTB_FIRST + 5'(gi);
            assign convD[gi] = (gi < sgpb_pkg::PORTD_CONV_PINS) &&
                (converterChannelSelect ==
                sgpb_pkg::CONV_PORTD_FIRST + 5'(gi));
            assign timerD[gi] = (gi == sgpb_pkg::TIMER_A_PIN && timerASel) ||
                (gi == sgpb_pkg::TIMER_B_PIN && timerBSel);
        end
    endgenerate

    assign timerASel = timerAPrescalerSelect == sgpb_pkg::PRESCALE_EXTERNAL;
    assign timerBSel = timerBPrescalerSelect == sgpb_pkg::PRESCALE_EXTERNAL;

    // Drive enables, active high before inversion.
    logic [7:0] driveB;
    logic [5:0] driveC;
    logic [7:0] driveD;
    assign driveB = portbDirection & ~convB;
    assign driveD = portdDirection & ~convD & ~timerD;
    assign driveC = clockOutputEnable ?
        (portcDirection | 6'h04) : portcDirection;

    // Read values seen by software.
    logic [7:0] portbRead;
    logic [7:0] portcRead;
    logic [7:0] portdRead;
    logic [7:0] portcRaw;
    // Latch or pin; converter input reads zero.
    assign portbRead = (portbDirection & portbData) |
        (~portbDirection & ~convB & pinSync.b);
    assign portcRaw = {2'h0, (portcDirection & portcData) |
        (~portcDirection & pinSync.c)};
    assign portcRead = clockOutputEnable ?
        (portcRaw & 8'hfb) : portcRaw;
    // Latch or pin; converter and timer inputs read zero.
    assign portdRead = (portdDirection & portdData) |
        (~portdDirection & ~convD & ~timerD & pinSync.d);

    // Read decode.
    logic [5:0] rdIdx;
    logic rdHit;
    logic [7:0] rdByte;
    assign rdIdx = araddr[sgpb_pkg::ADDR_W-1:sgpb_pkg::IDX_LSB];
    assign rdHit = araddr[1:0] == 2'h0 &&
        (rdIdx == sgpb_pkg::IDX_PORTB_DATA ||
        rdIdx == sgpb_pkg::IDX_PORTC_DATA ||
        rdIdx == sgpb_pkg::IDX_PORTD_DATA ||
        rdIdx == sgpb_pkg::IDX_PORTB_DIRECTION ||
        rdIdx == sgpb_pkg::IDX_PORTC_DIRECTION_CLKOUT ||
        rdIdx == sgpb_pkg::IDX_PORTD_DIRECTION);
    assign rdByte =
        rdIdx == sgpb_pkg::IDX_PORTB_DATA ? portbRead :
        rdIdx == sgpb_pkg::IDX_PORTC_DATA ? portcRead :
        rdIdx == sgpb_pkg::IDX_PORTD_DATA ? portdRead :
        rdIdx == sgpb_pkg::IDX_PORTB_DIRECTION ? portbDirection :
        rdIdx == sgpb_pkg::IDX_PORTC_DIRECTION_CLKOUT ?
            {clockOutputEnable, 1'b0, portcDirection} :
        rdIdx == sgpb_pkg::IDX_PORTD_DIRECTION ? portdDirection : 8'h00;

    // Write decode.
    logic [5:0] wrIdx;
    logic wrHit;
    logic wrB;
    logic wrC;
    logic wrD;
    logic wrDirB;
    logic wrDirC;
    logic wrDirD;
    assign wrIdx = wrAddr[sgpb_pkg::ADDR_W-1:sgpb_pkg::IDX_LSB];
    assign wrB = wrIdx == sgpb_pkg::IDX_PORTB_DATA;
    assign wrC = wrIdx == sgpb_pkg::IDX_PORTC_DATA;
    assign wrD = wrIdx == sgpb_pkg::IDX_PORTD_DATA;
    assign wrDirB = wrIdx == sgpb_pkg::IDX_PORTB_DIRECTION;
    assign wrDirC = wrIdx == sgpb_pkg::IDX_PORTC_DIRECTION_CLKOUT;
    assign wrDirD = wrIdx == sgpb_pkg::IDX_PORTD_DIRECTION;
    assign wrHit = wrAddr[1:0] == 2'h0 &&
        (wrB || wrC || wrD || wrDirB || wrDirC || wrDirD);
    assign wrDo = awHeld && wHeld && !bvalid;
    assign next_awHeld = wrDo ? 1'b0 : (awHeld || (awvalid && awready));
    assign next_wHeld = wrDo ? 1'b0 : (wHeld || (wvalid && wready));

    // Port C latch keeps the clock pin while clock-out is on.
    logic [5:0] portcKeep;
    logic [5:0] next_portcData;
    assign portcKeep = clockOutputEnable ? 6'h04 : 6'h00;
    assign next_portcData = (portcData & portcKeep) |
        (wrData[5:0] & ~portcKeep);

    // Pin synchronisers.
    always_ff @(posedge ref_clk) begin
        pinMeta <= pinsIn;
        pinSync <= pinMeta;
    end

    // Write channel capture.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= sgpb_pkg::RESP_OKAY;
            wrAddr <= '0;
            wrData <= 8'h00;
            wrLane <= 1'b0;
        end else begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awready <= !next_awHeld;
            wready <= !next_wHeld;
            if (awvalid && awready) begin
                wrAddr <= awaddr;
            end
            if (wvalid && wready) begin
                wrData <= wdata[7:0];
                wrLane <= wstrb[0];
            end
            if (wrDo) begin
                bvalid <= 1'b1;
                bresp <= wrHit ? sgpb_pkg::RESP_OKAY : sgpb_pkg::RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (wrDo && wrHit && wrLane) begin
            if (wrB) begin
                portbData <= wrData;
            end
            if (wrC) begin
                portcData <= next_portcData;
            end
            if (wrD) begin
                portdData <= wrData;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            portbDirection <= sgpb_pkg::DIRECTION_RESET;
            portcDirection <= sgpb_pkg::DIRECTION_RESET[5:0];
            clockOutputEnable <= 1'b0;
            portdDirection <= sgpb_pkg::DIRECTION_RESET;
        end else if (wrDo && wrHit && wrLane) begin
            if (wrDirB) begin
                portbDirection <= wrData;
            end
            if (wrDirC) begin
                portcDirection <= wrData[5:0];
                clockOutputEnable <= wrData[sgpb_pkg::CLKOUT_EN_BIT];
            end
            if (wrDirD) begin
                portdDirection <= wrData;
            end
        end
    end

    // Read channel.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= sgpb_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h000000, rdByte};
            rresp <= rdHit ? sgpb_pkg::RESP_OKAY : sgpb_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

    // Pin drivers.
    logic clockToggle;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pinsOeN <= {sgpb_pkg::OE_N_RESET, sgpb_pkg::OE_N_RESET[5:0],
                sgpb_pkg::OE_N_RESET};
            pinsOut <= '0;
            clockToggle <= 1'b0;
            timerAExternalClock <= 1'b0;
            timerBExternalClock <= 1'b0;
        end else begin
            pinsOeN.b <= ~driveB;
            pinsOeN.c <= ~driveC;
            pinsOeN.d <= ~driveD;
            pinsOut.b <= portbData;
            pinsOut.d <= portdData;
            clockToggle <= clockOutputEnable ? !clockToggle : 1'b0;
            pinsOut.c <= clockOutputEnable ?
                ((portcData & 6'h3b) | {3'h0, !clockToggle, 2'h0}) :
                portcData;
            timerAExternalClock <= timerASel &&
                pinSync.d[sgpb_pkg::TIMER_A_PIN];
            timerBExternalClock <= timerBSel &&
                pinSync.d[sgpb_pkg::TIMER_B_PIN];
        end
    end

    // Checks.
    logic [5:0] arIdxNow;
    assign arIdxNow = araddr[sgpb_pkg::ADDR_W-1:sgpb_pkg::IDX_LSB];

    chk_latch_b_keep: assert property (@(posedge ref_clk)
        srst && !wrDo |=> $stable(portbData))
        else $error("port B latch changed in reset");
    chk_latch_d_keep: assert property (@(posedge ref_clk)
        srst && !wrDo |=> $stable(portdData))
        else $error("port D latch changed in reset");
    chk_dir_reset: assert property (@(posedge ref_clk)
        srst |=> portbDirection == 8'h00 && portdDirection == 8'h00 &&
        portcDirection == 6'h00 && !clockOutputEnable ##1
        pinsOeN == {22{1'b1}})
        else $error("directions not cleared by reset");
    chk_b_drive: assert property (@(posedge ref_clk)
        disable iff (srst) !srst |=>
        pinsOeN.b == ~($past(portbDirection) & ~$past(convB)))
        else $error("port B drive wrong");
    chk_b_read: assert property (@(posedge ref_clk) disable iff (srst)
        arvalid && arready && arIdxNow == sgpb_pkg::IDX_PORTB_DATA &&
        araddr[1:0] == 2'h0 |=> rvalid && rdata[7:0] == $past(portbRead) &&
        rresp == sgpb_pkg::RESP_OKAY)
        else $error("port B read wrong");
    chk_conv_zero: assert property (@(posedge ref_clk)
        disable iff (srst) arvalid && arready &&
        arIdxNow == sgpb_pkg::IDX_PORTB_DATA && araddr[1:0] == 2'h0 |=>
        (rdata[7:0] & $past(convB) & ~$past(portbDirection)) == 8'h00)
        else $error("converter pin not read as zero");
    chk_write_any_dir: assert property (@(posedge ref_clk)
        disable iff (srst) wrDo && wrHit && wrLane && wrB |=>
        portbData == $past(wrData))
        else $error("port B latch not written");
    chk_clkout_toggle: assert property (@(posedge ref_clk)
        disable iff (srst) clockOutputEnable [*3] |->
        !pinsOeN.c[2] && pinsOut.c[2] != $past(pinsOut.c[2]))
        else $error("clock output not running");
    chk_clkout_read: assert property (@(posedge ref_clk)
        disable iff (srst) clockOutputEnable && arvalid && arready &&
        arIdxNow == sgpb_pkg::IDX_PORTC_DATA |=> rdata[2] == 1'b0)
        else $error("clock pin read not zero");
    chk_d_read: assert property (@(posedge ref_clk) disable iff (srst)
        arvalid && arready && arIdxNow == sgpb_pkg::IDX_PORTD_DATA &&
        araddr[1:0] == 2'h0 |=> rdata[7:0] == $past(portdRead))
        else $error("port D read wrong");
    chk_timer_drive: assert property (@(posedge ref_clk)
        disable iff (srst) timerASel ##1 timerASel |-> pinsOeN.d[6] ##1
        timerAExternalClock == $past(pinSync.d[6]))
        else $error("timer pin still driven");
    chk_timer_b_drive: assert property (@(posedge ref_clk)
        disable iff (srst) timerBSel ##1 timerBSel |-> pinsOeN.d[4] ##1
        timerBExternalClock == $past(pinSync.d[4]))
        else $error("timer B pin still driven");
    chk_c_read: assert property (@(posedge ref_clk)
        disable iff (srst) arvalid && arready &&
        arIdxNow == sgpb_pkg::IDX_PORTC_DATA && araddr[1:0] == 2'h0 |=>
        rdata[7:0] == $past(portcRead))
        else $error("port C read wrong");

    cov_clkout: cover property (@(posedge ref_clk) disable iff (srst)
        clockOutputEnable ##1 rvalid);
    cov_conv_read: cover property (@(posedge ref_clk) disable iff (srst)
        arvalid && arready && (convB & ~portbDirection) != 8'h00);
    cov_timer_sel: cover property (@(posedge ref_clk) disable iff (srst)
        timerBSel && portdDirection[4]);
    cov_d_conv_read: cover property (@(posedge ref_clk) disable iff (srst)
        arvalid && arready && (convD & ~portdDirection) != 8'h00);

endmodule

//--- tb/sgpb_pin_model.sv
module sgpb_pin_model (
    // Design side of the pins.
    input wire sgpb_pkg::sgpb_pins_t pinsOut,
    input wire sgpb_pkg::sgpb_pins_t pinsOeN,
    // Levels that outside circuits put on released pins.
    input wire sgpb_pkg::sgpb_pins_t extLevel,
    // Resolved pin levels.
    output sgpb_pkg::sgpb_pins_t pinsIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // A driven pin shows the design value, a released one the outside level.
    assign pinsIn = (pinsOut & ~pinsOeN) | (extLevel & pinsOeN);
endmodule

//--- tb/shared_gpio_ports_bcd_tb_top.sv
module shared_gpio_ports_bcd_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_B = {sgpb_pkg::IDX_PORTB_DATA, 2'h0};
    localparam logic [7:0] A_C = {sgpb_pkg::IDX_PORTC_DATA, 2'h0};
    localparam logic [7:0] A_D = {sgpb_pkg::IDX_PORTD_DATA, 2'h0};
    localparam logic [7:0] A_DB = {sgpb_pkg::IDX_PORTB_DIRECTION, 2'h0};
    localparam logic [7:0] A_DC = {sgpb_pkg::IDX_PORTC_DIRECTION_CLKOUT, 2'h0};
    localparam logic [7:0] A_DD = {sgpb_pkg::IDX_PORTD_DIRECTION, 2'h0};
    logic refClk, srst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, clkA, clkB, tog;
    logic [7:0] awaddr, araddr, lb, ld, db, dd, sb, sd;
    logic [31:0] wdata, rdata, rd, seed;
    logic [3:0] wstrb, wrStrb;
    logic [1:0] bresp, rresp, rsp;
    logic [4:0] convSel;
    logic [2:0] preA, preB;
    logic [5:0] lc, dc;
    sgpb_pkg::sgpb_pins_t pinsIn, pinsOut, pinsOeN, extLevel;
    int fails, numChecks, cycles;

    sgpb_top uut (.ref_clk(refClk), .srst(srst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .converterChannelSelect(convSel),
        .timerAPrescalerSelect(preA), .timerBPrescalerSelect(preB),
        .pinsIn(pinsIn), .pinsOut(pinsOut), .pinsOeN(pinsOeN),
        .timerAExternalClock(clkA), .timerBExternalClock(clkB));
    sgpb_pin_model pins (.pinsOut(pinsOut), .pinsOeN(pinsOeN),
        .extLevel(extLevel), .pinsIn(pinsIn));

    initial begin
        refClk = 1'b0;
        forever #20 refClk = ~refClk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] expRd(input logic [7:0] l, d, p, s);
        return (d & l) | (~d & p & ~s);
    endfunction

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [7:0] d,
        output logic [1:0] r);
        @(posedge refClk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= wrStrb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge refClk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge refClk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge refClk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic pulseReset();
        @(posedge refClk);
        srst <= 1'b1;
        @(posedge refClk);
        srst <= 1'b0;
    endtask

    always @(posedge refClk) begin
        cycles++;
        if (cycles == 8000) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        seed = 32'd34;
        wrStrb = 4'h1;
        fails = 0;
        numChecks = 0;
        cycles = 0;
        srst = 1'b1;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        convSel = 5'h1f;
        preA = 3'h0;
        preB = 3'h0;
        extLevel = '0;
        repeat (16) @(posedge refClk);
        srst <= 1'b0;
        lb = 8'(rnd());
        lc = 6'(rnd());
        ld = 8'(rnd());
        axw(A_B, lb, rsp);
        axw(A_C, {2'h0, lc}, rsp);
        axw(A_D, ld, rsp);
        pulseReset();
        axr(A_DB, rd, rsp); chk(rd, 32'h0);
        axr(A_DC, rd, rsp); chk(rd, 32'h0);
        axr(A_DD, rd, rsp); chk(rd, 32'h0);
        chk(32'(pinsOeN), 32'h3fffff);
        axw(A_DB, 8'hff, rsp);
        axw(A_DC, 8'h3f, rsp);
        axw(A_DD, 8'hff, rsp);
        axr(A_B, rd, rsp); chk(rd, {24'h0, lb});
        axr(A_C, rd, rsp); chk(rd, {26'h0, lc});
        axr(A_D, rd, rsp); chk(rd, {24'h0, ld});
        for (int i = 0; i < 16; i++) begin
            {lb, ld, db, dd} = rnd();
            {lc, dc} = 12'(rnd());
            extLevel <= 22'(rnd());
            axw(A_B, lb, rsp);
            axw(A_C, {2'h0, lc}, rsp);
            axw(A_D, ld, rsp);
            axw(A_DB, db, rsp);
            axw(A_DC, {2'h0, dc}, rsp);
            axw(A_DD, dd, rsp); chk(rsp, sgpb_pkg::RESP_OKAY);
            repeat (4) @(posedge refClk);
            chk(32'(pinsOeN), {10'h0, ~{db, dc, dd}});
            chk({10'h0, pinsOut & ~pinsOeN},
                {10'h0, lb & db, lc & dc, ld & dd});
            axr(A_B, rd, rsp);
            chk(rd, expRd(lb, db, extLevel.b, 8'h0));
            axr(A_C, rd, rsp);
            chk(rd, expRd(8'(lc), 8'(dc), 8'(extLevel.c), 8'h0));
            axr(A_D, rd, rsp);
            chk(rd, expRd(ld, dd, extLevel.d, 8'h0));
        end
        for (int ch = 0; ch < 15; ch++) begin
            sb = (ch < 8) ? 8'(1 << ch) : 8'h0;
            sd = (ch >= 8) ? 8'(1 << (ch - 8)) : 8'h0;
            convSel <= 5'(ch);
            repeat (4) @(posedge refClk);
            chk({pinsOeN.b, pinsOeN.d}, {16'h0, ~{db & ~sb, dd & ~sd}});
            axr(A_B, rd, rsp); chk(rd, expRd(lb, db, extLevel.b, sb));
            axr(A_D, rd, rsp); chk(rd, expRd(ld, dd, extLevel.d, sd));
        end
        convSel <= 5'h1f;
        axw(A_DD, 8'hff, rsp);
        for (int p = 0; p < 8; p++) begin
            preA <= 3'(p);
            preB <= 3'(p);
            extLevel <= 22'(rnd());
            repeat (5) @(posedge refClk);
            chk(clkA, (p == 7) & extLevel.d[6]);
            chk(clkB, (p == 7) & extLevel.d[4]);
            chk(pinsOeN.d, (p == 7) ? 8'h50 : 8'h00);
        end
        preA <= 3'h0;
        preB <= 3'h0;
        axw(A_DC, 8'h80, rsp);
        axw(A_C, 8'hff, rsp);
        repeat (3) @(posedge refClk);
        chk(pinsOeN.c, 6'h3b);
        tog = pinsOut.c[2];
        @(posedge refClk);
        chk(pinsOut.c[2], !tog);
        axr(A_C, rd, rsp); chk(rd, 32'(extLevel.c & 6'h3b));
        axr(A_DC, rd, rsp); chk(rd, 32'h80);
        pulseReset();
        axr(A_DC, rd, rsp); chk(rd, 32'h0);
        chk(pinsOeN.c, 6'h3f);
        wrStrb = 4'h0;
        axw(A_DB, 8'h5a, rsp);
        chk(rsp, sgpb_pkg::RESP_OKAY);
        axr(A_DB, rd, rsp);
        chk(rd, 32'h0);
        wrStrb = 4'h1;
        axw(8'h40, 8'h55, rsp); chk(rsp, sgpb_pkg::RESP_SLVERR);
        axr(8'h40, rd, rsp);
        chk(rd, 32'h0);
        chk(rsp, sgpb_pkg::RESP_SLVERR);
        axr(8'h05, rd, rsp); chk(rsp, sgpb_pkg::RESP_SLVERR);
        complete_run();
    end
endmodule
